// *** src/vcp_device.sv ***
`timescale 1ns/1ps
// device end: byte port, control registers, status, VRAM request path
module vcp_device (
  input wire logic clk_in, // 50 MHz clock
  input wire logic rst_in, // sync reset, high
  vcp_if.device port, // host pins
  output logic [7:0] ctrl_reg_out [8], // control registers, logical bit order
  input wire logic frame_event_in, // end of active display pulse
  input wire logic coinc_event_in, // sprite coincidence pulse
  input wire logic fifth_event_in, // fifth sprite pulse
  input wire logic [4:0] fifth_num_in, // fifth sprite number
  output logic vram_req_out, // VRAM access request
  output logic vram_we_out, // 1 write, 0 read
  output logic [13:0] vram_addr_out, // VRAM address
  output logic [7:0] vram_wdata_out, // VRAM write data
  input wire logic vram_grant_in, // arbiter window grant
  input wire logic [7:0] vram_rdata_in // read data with grant
);
  // strobe edge detection (pins taken as synchronous)
  logic wr_prev;
  logic rd_prev;
  wire wr_act = !port.host_write_strobe_n;
  wire rd_act = !port.host_read_strobe_n;
  wire wr_start = wr_act && !wr_prev;
  wire rd_end = !rd_act && rd_prev;
  wire [7:0] bus_byte = vcp_pkg::vcp_swap(port.host_byte_bus);
  wire ctl_wr = wr_start && port.mode;
  wire dat_wr = wr_start && !port.mode;
  wire st_rd_end = rd_end && port.mode;
  wire dat_rd_end = rd_end && !port.mode;

  logic second;
  logic [7:0] first_byte;
  logic [13:0] vaddr;
  logic [7:0] prefetch;
  logic pf_pending;
  logic int_flag;
  logic coinc_flag;
  logic fifth_flag;
  logic [4:0] fifth_num;
  logic [7:0] rd_byte;

  wire [1:0] pfx = bus_byte[7:6];
  wire is_reg = ctl_wr && second && pfx == vcp_pkg::PFX_REG;
  wire is_wset = ctl_wr && second && pfx == vcp_pkg::PFX_WR;
  wire is_rset = ctl_wr && second && pfx == vcp_pkg::PFX_RD;
  wire [13:0] setup_addr = {bus_byte[5:0], first_byte};
  wire [13:0] vaddr_inc = vaddr + 14'h0001;
  wire [7:0] status_byte = {int_flag, fifth_flag, coinc_flag, fifth_num};

  // write path and prefetch requests share a FIFO toward the arbiter
  // a data read refetches from the next address, since the current byte is already held
  wire [22:0] q_in = {dat_wr, dat_wr ? vaddr : (is_rset ? setup_addr : vaddr_inc), bus_byte};
  wire q_push = dat_wr || is_rset || dat_rd_end;
  wire q_ready;
  wire [22:0] q_head;
  wire q_valid;

  vcp_fifo #(.WIDTH(23), .DEPTH(vcp_pkg::FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_data_in(q_in),
    .in_valid_in(q_push),
    .in_ready_out(q_ready),
    .out_data_out(q_head),
    .out_valid_out(q_valid),
    .out_ready_in(vram_grant_in)
  );

  // edge history
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
    end else begin
      wr_prev <= wr_act;
      rd_prev <= rd_act;
    end
  end

  // byte sequencing and address register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second <= 1'b0;
      first_byte <= vcp_pkg::BYTE_RST;
      vaddr <= vcp_pkg::ADDR_RST;
    end else begin
      if (st_rd_end || dat_wr || dat_rd_end) begin
        second <= 1'b0;
      end else if (ctl_wr) begin
        second <= !second;
      end
      if (ctl_wr && !second) first_byte <= bus_byte;
      if (is_wset || is_rset) begin
        vaddr <= setup_addr; // (register loads skip this)
      end else if ((dat_wr && q_ready) || dat_rd_end) begin
        vaddr <= vaddr_inc;
      end
    end
  end

  // control registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < vcp_pkg::REG_CNT; i++) ctrl_reg_out[i] <= vcp_pkg::BYTE_RST;
    end else if (is_reg) begin
      ctrl_reg_out[bus_byte[2:0]] <= first_byte;
    end
  end

  // status flags: an event in the clearing cycle survives
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      int_flag <= 1'b0;
      coinc_flag <= 1'b0;
      fifth_flag <= 1'b0;
      fifth_num <= 5'h00;
    end else begin
      int_flag <= frame_event_in || (int_flag && !st_rd_end);
      coinc_flag <= coinc_event_in || (coinc_flag && !st_rd_end);
      fifth_flag <= fifth_event_in || (fifth_flag && !st_rd_end); // set wins over clear
      if (fifth_event_in && (!fifth_flag || st_rd_end)) fifth_num <= fifth_num_in;
    end
  end

  // prefetch capture; only read requests return data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prefetch <= vcp_pkg::BYTE_RST;
      pf_pending <= 1'b0;
    end else begin
      if (vram_grant_in && q_valid && !q_head[22]) begin
        prefetch <= vram_rdata_in;
      end
      pf_pending <= q_valid;
    end
  end

  // read bus: reload the output byte every cycle, drive while strobe is low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_byte <= vcp_pkg::BYTE_RST;
      port.host_bus_d_oe_n <= 1'b1;
      port.host_bus_d_out <= 8'h00;
      port.int_n <= 1'b1;
    end else begin
      port.host_bus_d_oe_n <= !rd_act;
      port.host_bus_d_out <= vcp_pkg::vcp_swap(port.mode ? status_byte : prefetch);
      port.int_n <= !(int_flag && ctrl_reg_out[1][5] && !st_rd_end);
      rd_byte <= status_byte;
    end
  end

  // arbiter request straight from queue head
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vram_req_out <= 1'b0;
      vram_we_out <= 1'b0;
      vram_addr_out <= vcp_pkg::ADDR_RST;
      vram_wdata_out <= vcp_pkg::BYTE_RST;
    end else begin
      vram_req_out <= q_valid && !vram_grant_in;
      vram_we_out <= q_head[22];
      vram_addr_out <= q_head[21:8];
      vram_wdata_out <= q_head[7:0];
    end
  end
endmodule : vcp_device

// *** src/vcp_pkg.sv ***
package vcp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 14;
  localparam int REG_CNT = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_HZ = 50_000_000;
  localparam int SETUP_TIME_NS = 2000; // two microseconds per setup byte / status read
  localparam int SETUP_CYC = (SETUP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STROBE_CYC = 4; // host strobe length
  localparam logic [1:0] PFX_REG = 2'h2;
  localparam logic [1:0] PFX_WR = 2'h1;
  localparam logic [1:0] PFX_RD = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam int ST_INT_BIT = 0; // bus bit 0 is the byte's MSB
  localparam int ST_COINC_BIT = 2;
  localparam int ST_FIFTH_BIT = 1;

  // bus bit i carries logical bit 7-i
  function automatic logic [DATA_W-1:0] vcp_swap(input logic [DATA_W-1:0] b);
    for (int i = 0; i < DATA_W; i++) begin
      vcp_swap[i] = b[DATA_W-1-i];
    end
  endfunction : vcp_swap

  typedef enum logic [4:0] {
    VCP_IDLE = 5'h01,
    VCP_STB = 5'h02,
    VCP_HOLD = 5'h04,
    VCP_GAP = 5'h08,
    VCP_DONE = 5'h10
  } vcp_host_state_type;
endpackage : vcp_pkg

// *** src/vcp_if.sv ***
`timescale 1ns/1ps
// host port pins; bus bit 0 is the most significant bit
interface vcp_if;
  logic host_write_strobe_n;
  logic host_read_strobe_n;
  logic mode;
  logic [7:0] host_bus_h_out;
  logic host_bus_h_oe_n;
  logic [7:0] host_bus_d_out;
  logic host_bus_d_oe_n;
  logic int_n;
  wire [7:0] host_byte_bus = !host_bus_d_oe_n ? host_bus_d_out : (!host_bus_h_oe_n ? host_bus_h_out : 8'hFF);
  modport device (input host_write_strobe_n, host_read_strobe_n, mode, host_byte_bus,
                  output host_bus_d_out, host_bus_d_oe_n, int_n);
  modport host (output host_write_strobe_n, host_read_strobe_n, mode, host_bus_h_out, host_bus_h_oe_n,
                input host_byte_bus, int_n);
endinterface : vcp_if

// *** src/vcp_fifo.sv ***
`timescale 1ns/1ps
// small synchronous FIFO with valid/ready on both sides
module vcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in, // clock
  input wire logic rst_in, // sync reset
  input wire logic [WIDTH-1:0] in_data_in, // write data
  input wire logic in_valid_in, // write request
  output logic in_ready_out, // not full
  output logic [WIDTH-1:0] out_data_out, // head word
  output logic out_valid_out, // not empty
  input wire logic out_ready_in // pop
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  // storage has no reset; pointers alone define contents
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : vcp_fifo

// *** src/vcp_host.sv ***
`timescale 1ns/1ps
// host end: runs one byte transfer per command, spaced by setup time
module vcp_host (
  input wire logic clk_in, // 50 MHz clock
  input wire logic rst_in, // sync reset, high
  vcp_if.host port, // device pins
  input wire logic cmd_valid_in, // command request
  input wire logic cmd_read_in, // 1 read, 0 write
  input wire logic cmd_mode_in, // mode line level
  input wire logic [7:0] cmd_data_in, // write byte, logical order
  output logic cmd_ready_out, // idle and accepting
  output logic rsp_valid_out, // read byte pulse
  output logic [7:0] rsp_data_out, // read byte, logical order
  output logic irq_out // device interrupt, active high
);
  vcp_pkg::vcp_host_state_type state;
  logic [11:0] cnt;
  logic is_read;
  wire cnt_zero = (cnt == 12'h000);

  // one transfer: strobe, hold, then gap so setup and status spacing holds
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= vcp_pkg::VCP_IDLE;
      cnt <= 12'h000;
      is_read <= 1'b0;
      port.host_write_strobe_n <= 1'b1;
      port.host_read_strobe_n <= 1'b1;
      port.mode <= 1'b1;
      port.host_bus_h_out <= 8'h00;
      port.host_bus_h_oe_n <= 1'b1;
      cmd_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      irq_out <= !port.int_n;
      rsp_valid_out <= 1'b0;
      unique case (state)
        vcp_pkg::VCP_IDLE: begin
          if (cmd_valid_in) begin
            state <= vcp_pkg::VCP_STB;
            cmd_ready_out <= 1'b0;
            is_read <= cmd_read_in;
            port.mode <= cmd_mode_in;
            port.host_bus_h_out <= vcp_pkg::vcp_swap(cmd_data_in);
            port.host_bus_h_oe_n <= cmd_read_in;
            cnt <= 12'(vcp_pkg::STROBE_CYC - 1);
          end
        end
        vcp_pkg::VCP_STB: begin
          // never both strobes low
          port.host_write_strobe_n <= is_read;
          port.host_read_strobe_n <= !is_read;
          state <= vcp_pkg::VCP_HOLD;
        end
        vcp_pkg::VCP_HOLD: begin
          if (cnt_zero) begin
            if (is_read) rsp_data_out <= vcp_pkg::vcp_swap(port.host_byte_bus);
            rsp_valid_out <= is_read;
            port.host_write_strobe_n <= 1'b1;
            port.host_read_strobe_n <= 1'b1;
            cnt <= 12'(vcp_pkg::SETUP_CYC - 1);
            state <= vcp_pkg::VCP_GAP;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        vcp_pkg::VCP_GAP: begin
          port.host_bus_h_oe_n <= 1'b1;
          if (cnt_zero) begin
            state <= vcp_pkg::VCP_DONE;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        vcp_pkg::VCP_DONE: begin
          cmd_ready_out <= 1'b1;
          state <= vcp_pkg::VCP_IDLE;
        end
      endcase
    end
  end
endmodule : vcp_host

// *** testbench/vcp_checker.sv ***
`timescale 1ns/1ps
// watches the host port wires between the two ends
module vcp_checker (
  input wire logic clk_in, // clock
  input wire logic rst_in, // sync reset, high
  input wire logic host_write_strobe_n, // write select
  input wire logic host_read_strobe_n, // read select
  input wire logic mode, // mode line
  input wire logic host_bus_h_oe_n, // host drive enable
  input wire logic host_bus_d_oe_n, // device drive enable
  input wire logic int_n, // interrupt
  input wire logic [7:0] host_byte_bus // resolved bus
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] gap;

  // cycles since the last strobe fell; saturates so reset reads as long idle
  always_ff @(posedge clk_in) begin
    if (rst_in) gap <= 8'hFF;
    else if ($fell(host_write_strobe_n) || $fell(host_read_strobe_n)) gap <= 8'h00;
    else if (gap != 8'hFF) gap <= gap + 8'h01;
  end

  AST_ONE_STROBE: assert property (host_write_strobe_n || host_read_strobe_n)
    else $error("both strobes low");
  AST_NO_CLASH: assert property (host_bus_h_oe_n || host_bus_d_oe_n)
    else $error("both ends drive the bus");
  AST_READ_DRIVES: assert property (!host_read_strobe_n [*3] |-> !host_bus_d_oe_n)
    else $error("device silent during read");
  AST_IDLE_RELEASE: assert property (host_read_strobe_n [*3] |-> host_bus_d_oe_n)
    else $error("device holds bus outside read");
  AST_STROBE_WIDTH: assert property ($fell(host_write_strobe_n) |->
    !host_write_strobe_n [*4] ##1 host_write_strobe_n) else $error("write strobe width");
  AST_WRITE_HOLD: assert property (!host_write_strobe_n && $past(!host_write_strobe_n) |->
    $stable(host_byte_bus) && $stable(mode) && !host_bus_h_oe_n) else $error("write byte moved");
  AST_READ_MODE: assert property (!host_read_strobe_n && $past(!host_read_strobe_n) |-> $stable(mode))
    else $error("mode moved in read");
  AST_SPACING: assert property ($fell(host_write_strobe_n) || $fell(host_read_strobe_n) |-> gap >= 8'd99)
    else $error("strobes too close");
  AST_INT_ACK: assert property ((!host_read_strobe_n && mode && !int_n) ##1 host_read_strobe_n |->
    ##[1:4] int_n) else $error("interrupt not cleared");

  cover property ($rose(host_read_strobe_n) && mode);
  cover property ($fell(host_write_strobe_n) && !mode);
  cover property ($fell(host_read_strobe_n) && !mode);
endmodule : vcp_checker

// *** testbench/video_processor_cpu_port_bench.sv ***
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %s", $time, m); end end
module video_processor_cpu_port_bench;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  int n_errors = 0;
  int n_checks = 0;
  logic cmd_valid = 1'h0, cmd_read = 1'h0, cmd_mode = 1'h0, grant = 1'h0;
  logic frame = 1'h0, coinc = 1'h0, fifth = 1'h0, hold = 1'h0;
  logic cmd_ready, rsp_valid, irq, req, we;
  logic [7:0] cmd_data = 8'h00, rdata = 8'h00, rsp, rsp_data, wdata;
  logic [13:0] addr;
  logic [7:0] regs [8];
  logic [21:0] wq [$];
  int wait_cnt = 0;

  vcp_if link ();
  always #10 clk_in = ~clk_in;

  vcp_device i_vcp_device (.clk_in(clk_in), .rst_in(rst_in), .port(link.device), .ctrl_reg_out(regs),
    .frame_event_in(frame), .coinc_event_in(coinc), .fifth_event_in(fifth), .fifth_num_in(5'h15),
    .vram_req_out(req), .vram_we_out(we), .vram_addr_out(addr), .vram_wdata_out(wdata),
    .vram_grant_in(grant), .vram_rdata_in(rdata));
  vcp_host i_vcp_host (.clk_in(clk_in), .rst_in(rst_in), .port(link.host), .cmd_valid_in(cmd_valid),
    .cmd_read_in(cmd_read), .cmd_mode_in(cmd_mode), .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .irq_out(irq));
  vcp_checker i_vcp_checker (.clk_in(clk_in), .rst_in(rst_in), .host_write_strobe_n(link.host_write_strobe_n),
    .host_read_strobe_n(link.host_read_strobe_n), .mode(link.mode), .host_bus_h_oe_n(link.host_bus_h_oe_n),
    .host_bus_d_oe_n(link.host_bus_d_oe_n), .int_n(link.int_n), .host_byte_bus(link.host_byte_bus));

  // memory side grants after a short window delay; read data is the inverted low address
  always @(posedge clk_in) begin
    grant <= 1'h0;
    if (req === 1'h1 && !grant && !hold && wait_cnt < 3) wait_cnt <= wait_cnt + 1;
    else if (req === 1'h1 && !grant && !hold) begin
      grant <= 1'h1;
      rdata <= ~addr[7:0];
      wait_cnt <= 0;
      if (we === 1'h1) wq.push_back({addr, wdata});
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // one settled cycle; a wait that runs past its bound ends the run
  task automatic step(inout int k, input int lim);
    @(posedge clk_in);
    #1;
    k++;
    if (k > lim) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, "wait timed out");
      finish_test();
    end
  endtask : step

  // one host transfer; watches the wire while it runs
  task automatic cmd(input logic rd, input logic md, input logic [7:0] d);
    int k;
    logic [7:0] flip;
    for (int i = 0; i < 8; i++) flip[i] = d[7 - i];
    k = 0;
    do step(k, 400); while (cmd_ready !== 1'h1);
    @(posedge clk_in);
    cmd_valid <= 1'h1;
    cmd_read <= rd;
    cmd_mode <= md;
    cmd_data <= d;
    @(posedge clk_in);
    cmd_valid <= 1'h0;
    k = 0;
    do step(k, 20); while ((rd ? link.host_read_strobe_n : link.host_write_strobe_n) !== 1'h0);
    `CHK(link.mode, md, "mode level")
    if (!rd) `CHK(link.host_byte_bus, flip, "bus bit order")
    k = 0;
    do step(k, 20); while (rd ? rsp_valid !== 1'h1 : link.host_write_strobe_n !== 1'h1);
    rsp = rsp_data;
  endtask : cmd

  task automatic set_addr(input logic [13:0] a, input logic [1:0] pfx);
    cmd(1'h0, 1'h1, a[7:0]);
    cmd(1'h0, 1'h1, {pfx, a[13:8]});
  endtask : set_addr

  task automatic load_reg(input logic [2:0] r, input logic [7:0] v);
    cmd(1'h0, 1'h1, v);
    cmd(1'h0, 1'h1, {5'h10, r});
  endtask : load_reg

  // grants withheld: one write more than the queue holds is refused, the rest drain in order
  task automatic sc_fifo();
    int k;
    int m;
    set_addr(14'h0200, vcp_pkg::PFX_WR);
    @(posedge clk_in);
    hold <= 1'h1;
    for (int i = 0; i <= vcp_pkg::FIFO_DEPTH; i++) cmd(1'h0, 1'h0, i[7:0]);
    @(posedge clk_in);
    hold <= 1'h0;
    k = 0;
    while (wq.size() < vcp_pkg::FIFO_DEPTH) step(k, 300);
    repeat (20) @(posedge clk_in);
    `CHK(wq.size(), vcp_pkg::FIFO_DEPTH, "words before refusal")
    m = 0;
    for (int i = 0; i < vcp_pkg::FIFO_DEPTH; i++) begin
      `CHK(wq[i], {14'h0200 + i[13:0], i[7:0]}, "fifo order")
      if (wq[i] === {14'h0200 + i[13:0], i[7:0]}) m++;
    end
    `CHK(m, vcp_pkg::FIFO_DEPTH, "words drained")
    wq.delete();
  endtask : sc_fifo

  // register loads between data writes must not disturb the address
  task automatic sc_write_regs();
    int k;
    set_addr(14'h1234, vcp_pkg::PFX_WR);
    cmd(1'h0, 1'h0, 8'h11);
    cmd(1'h0, 1'h0, 8'h22);
    for (int r = 0; r < 8; r++) load_reg(r[2:0], 8'hA0 + r[7:0]);
    for (int r = 0; r < 8; r++) `CHK(regs[r], 8'hA0 + r[7:0], "control register")
    cmd(1'h0, 1'h0, 8'h33);
    k = 0;
    while (wq.size() < 3) step(k, 50);
    `CHK(wq[0], {14'h1234, 8'h11}, "first vram write")
    `CHK(wq[1], {14'h1235, 8'h22}, "second vram write")
    `CHK(wq[2], {14'h1236, 8'h33}, "write after register loads")
  endtask : sc_write_regs

  task automatic sc_read();
    set_addr(14'h0100, vcp_pkg::PFX_RD);
    cmd(1'h1, 1'h0, 8'h00);
    `CHK(rsp, 8'hFF, "prefetched byte")
    cmd(1'h1, 1'h0, 8'h00);
    `CHK(rsp, 8'hFE, "byte after increment")
  endtask : sc_read

  // flags and interrupt raised, then cleared by a status read
  task automatic sc_status();
    int k;
    load_reg(3'h1, 8'h20);
    @(posedge clk_in);
    frame <= 1'h1;
    coinc <= 1'h1;
    fifth <= 1'h1;
    @(posedge clk_in);
    frame <= 1'h0;
    coinc <= 1'h0;
    fifth <= 1'h0;
    k = 0;
    do step(k, 10); while (irq !== 1'h1);
    `CHK(link.int_n, 1'h0, "interrupt pin low")
    cmd(1'h1, 1'h1, 8'h00);
    `CHK(rsp, 8'hF5, "status flags")
    cmd(1'h1, 1'h1, 8'h00);
    `CHK(rsp[7:5], 3'h0, "flags cleared")
    `CHK(irq, 1'h0, "interrupt cleared")
  endtask : sc_status

  // a lone first byte is forgotten after a status read
  task automatic sc_toggle();
    cmd(1'h0, 1'h1, 8'h55);
    cmd(1'h1, 1'h1, 8'h00);
    load_reg(3'h2, 8'h3C);
    `CHK(regs[2], 8'h3C, "sequence restarted")
  endtask : sc_toggle

  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'h0;
    sc_fifo();
    sc_write_regs();
    sc_read();
    sc_status();
    sc_toggle();
    finish_test();
  end
endmodule : video_processor_cpu_port_bench
